/* File: common/ccr_defs.svh */
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

// Register offsets
`define CCR_ADDR_POWER_MODE   8'h08
`define CCR_ADDR_CLOCK_COND   8'h09
`define CCR_ADDR_TEST_SEL     8'h0D
`define CCR_ADDR_OFFSET_TRIM  8'h10
`define CCR_ADDR_OUT_DRIVER   8'h14
`define CCR_ADDR_OUT_PHASE    8'h16
`define CCR_ADDR_REF_LEVEL    8'h18

// Reset values
`define CCR_RST_POWER_MODE    8'h00
`define CCR_RST_CLOCK_COND    8'h01
`define CCR_RST_TEST_SEL      8'h00
`define CCR_RST_OFFSET_TRIM   8'h00
`define CCR_RST_OUT_DRIVER    8'h00
`define CCR_RST_OUT_PHASE     8'h00
`define CCR_RST_REF_LEVEL     8'hC0

// Populated bit masks
`define CCR_MASK_POWER_MODE   8'h27
`define CCR_MASK_CLOCK_COND   8'h01
`define CCR_MASK_TEST_SEL     8'h37
`define CCR_MASK_OFFSET_TRIM  8'h3F
`define CCR_MASK_OUT_DRIVER   8'hD7
`define CCR_MASK_OUT_PHASE    8'h80
`define CCR_MASK_REF_LEVEL    8'hC0

// Field positions
`define CCR_PWR_MODE_LSB      0
`define CCR_PWR_PIN_FUNC_BIT  5
`define CCR_DCS_EN_BIT        0
`define CCR_TEST_SEL_LSB      0
`define CCR_SHORT_PRBS_RST    4
`define CCR_LONG_PRBS_RST     5
`define CCR_DRV_FORMAT_LSB    0
`define CCR_DRV_INVERT_BIT    2
`define CCR_DRV_DISABLE_BIT   4
`define CCR_DRV_STRENGTH_LSB  6
`define CCR_PHASE_INV_BIT     7
`define CCR_REF_CODE_LSB      6

// Power mode codes
`define CCR_PM_NORMAL_A       3'h0
`define CCR_PM_FULL_DOWN      3'h1
`define CCR_PM_STANDBY        3'h2
`define CCR_PM_NORMAL_B       3'h3

// Reference levels in millivolts
`define CCR_REF_MV_CODE0      12'h4E2
`define CCR_REF_MV_CODE1      12'h5DC
`define CCR_REF_MV_CODE2      12'h6D6
`define CCR_REF_MV_CODE3      12'h7D0

// Pattern words
`define CCR_PAT_MIDSCALE      12'h800
`define CCR_PAT_POS_FULL      12'hFFF
`define CCR_PAT_NEG_FULL      12'h000
`define CCR_PAT_CHECK_A       12'hAAA
`define CCR_PAT_CHECK_B       12'h555
`define CCR_LONG_PRBS_SEED    23'h7FFFFF
`define CCR_SHORT_PRBS_SEED   9'h1FF

`endif

/* File: common/ccr_pkg.sv */
package ccr_pkg;

  // Effective converter power state, one-hot
  typedef enum logic [2:0] {
    CCR_PWR_NORMAL   = 3'b001,
    CCR_PWR_STANDBY  = 3'b010,
    CCR_PWR_DOWN     = 3'b100
  } ccr_power_type;

  // Output test selector codes
  typedef enum logic [2:0] {
    CCR_TP_OFF       = 3'h0,
    CCR_TP_MIDSCALE  = 3'h1,
    CCR_TP_POS_FULL  = 3'h2,
    CCR_TP_NEG_FULL  = 3'h3,
    CCR_TP_CHECKER   = 3'h4,
    CCR_TP_LONG_PRBS = 3'h5,
    CCR_TP_SHORT_PRBS = 3'h6,
    CCR_TP_TOGGLE    = 3'h7
  } ccr_pattern_type;

endpackage : ccr_pkg

/* File: core/ccr_pattern_gen.sv */
`timescale 1ns/1ps
`include "ccr_defs.svh"

module ccr_pattern_gen
  import ccr_pkg::*;
#(
  parameter int DATA_W = 12
)(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire ccr_pattern_type   pattern_sel,
  input  wire logic              long_prbs_hold,
  input  wire logic              short_prbs_hold,
  input  wire logic [DATA_W-1:0] conv_data,
  output logic      [DATA_W-1:0] pattern_data
);

  logic [22:0]       long_prbs_reg;
  logic [22:0]       long_prbs_next;
  logic [8:0]        short_prbs_reg;
  logic [8:0]        short_prbs_next;
  logic              phase_reg;
  logic [DATA_W-1:0] word_next;

  // Long sequence x^23 + x^18 + 1, short x^9 + x^5 + 1
  assign long_prbs_next  = long_prbs_hold ? `CCR_LONG_PRBS_SEED
                         : {long_prbs_reg[21:0],
                            long_prbs_reg[22] ^ long_prbs_reg[17]};
  assign short_prbs_next = short_prbs_hold ? `CCR_SHORT_PRBS_SEED
                         : {short_prbs_reg[7:0],
                            short_prbs_reg[8] ^ short_prbs_reg[4]};

  // Word selection per test code
  always_comb
  begin
    case (pattern_sel)
      CCR_TP_OFF:        word_next = conv_data;
      CCR_TP_MIDSCALE:   word_next = `CCR_PAT_MIDSCALE;
      CCR_TP_POS_FULL:   word_next = `CCR_PAT_POS_FULL;
      CCR_TP_NEG_FULL:   word_next = `CCR_PAT_NEG_FULL;
      CCR_TP_CHECKER:    word_next = phase_reg ? `CCR_PAT_CHECK_B
                                               : `CCR_PAT_CHECK_A;
      CCR_TP_LONG_PRBS:  word_next = long_prbs_reg[DATA_W-1:0];
      CCR_TP_SHORT_PRBS: word_next = {{(DATA_W-9){1'b0}}, short_prbs_reg};
      CCR_TP_TOGGLE:     word_next = phase_reg ? `CCR_PAT_NEG_FULL
                                               : `CCR_PAT_POS_FULL;
      default:           word_next = conv_data;
    endcase
  end

  // Generator state and registered output word
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      long_prbs_reg  <= `CCR_LONG_PRBS_SEED;
      short_prbs_reg <= `CCR_SHORT_PRBS_SEED;
      phase_reg      <= 1'b0;
      pattern_data   <= '0;
    end
    else
    begin
      long_prbs_reg  <= long_prbs_next;
      short_prbs_reg <= short_prbs_next;
      phase_reg      <= ~phase_reg;
      pattern_data   <= word_next;
    end
  end

endmodule : ccr_pattern_gen

/* File: core/ccr_config_regs.sv */
// Function
// - Power field 001 is full power-down, 010 standby, 000 or 011 normal, and the power-down pin overrides it.
// - The test selector picks off, midscale, +full, -full, checkerboard, long PRBS, short PRBS or one/zero toggle.
// - Reference code 00/01/10/11 selects 1.25/1.5/1.75/2.00 V from the internal divider.
// - Data outputs drive only with the disable bit clear and the output-enable pin high.
// - Reset loads every register with its default before any write counts.
`timescale 1ns/1ps
`include "ccr_defs.svh"

module ccr_config_regs
  import ccr_pkg::*;
#(
  parameter int DATA_W = 12
)(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              reg_wr_en,
  input  wire logic              reg_rd_en,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wr_data,
  output logic      [7:0]        reg_rd_data,
  output logic                   reg_rd_valid,
  input  wire logic              power_down_pin,
  input  wire logic              output_enable_low_pin,
  input  wire logic [DATA_W-1:0] conv_data,
  output logic      [DATA_W-1:0] out_data,
  output logic                   out_data_oe,
  output logic      [1:0]        out_drive_strength,
  output logic      [1:0]        out_data_format,
  output logic                   sample_clock_invert,
  output logic                   dcs_enable,
  output logic      [5:0]        offset_trim,
  output logic      [1:0]        ref_code,
  output logic      [11:0]       ref_level_mv,
  output ccr_power_type          power_state
);

  // Keep only populated bits of a value
  function automatic logic [7:0] ccr_masked(input logic [7:0] value,
                                            input logic [7:0] mask);
    ccr_masked = value & mask;
  endfunction : ccr_masked

  // Reference level for a divider code
  function automatic logic [11:0] ccr_ref_mv(input logic [1:0] code);
    case (code)
      2'h0:    ccr_ref_mv = `CCR_REF_MV_CODE0;
      2'h1:    ccr_ref_mv = `CCR_REF_MV_CODE1;
      2'h2:    ccr_ref_mv = `CCR_REF_MV_CODE2;
      default: ccr_ref_mv = `CCR_REF_MV_CODE3;
    endcase
  endfunction : ccr_ref_mv

  logic [7:0]        power_mode_reg;
  logic [7:0]        clock_cond_reg;
  logic [7:0]        test_sel_reg;
  logic [7:0]        offset_trim_reg;
  logic [7:0]        out_driver_reg;
  logic [7:0]        out_phase_reg;
  logic [7:0]        ref_level_reg;
  logic [2:0]        power_down_pin_sync_reg;
  logic [2:0]        oe_sync_reg;
  logic              power_down_pin_level_reg;
  logic              oe_level_reg;
  logic [DATA_W-1:0] pattern_word;
  logic [7:0]        rd_data_next;
  ccr_power_type     power_next;

  // Address decode strobes
  wire wr_power  = reg_wr_en && (reg_addr == `CCR_ADDR_POWER_MODE);
  wire wr_clock  = reg_wr_en && (reg_addr == `CCR_ADDR_CLOCK_COND);
  wire wr_test   = reg_wr_en && (reg_addr == `CCR_ADDR_TEST_SEL);
  wire wr_offset = reg_wr_en && (reg_addr == `CCR_ADDR_OFFSET_TRIM);
  wire wr_driver = reg_wr_en && (reg_addr == `CCR_ADDR_OUT_DRIVER);
  wire wr_phase  = reg_wr_en && (reg_addr == `CCR_ADDR_OUT_PHASE);
  wire wr_ref    = reg_wr_en && (reg_addr == `CCR_ADDR_REF_LEVEL);

  // Masked write data per register
  wire [7:0] wd_power  = ccr_masked(reg_wr_data, `CCR_MASK_POWER_MODE);
  wire [7:0] wd_clock  = ccr_masked(reg_wr_data, `CCR_MASK_CLOCK_COND);
  wire [7:0] wd_test   = ccr_masked(reg_wr_data, `CCR_MASK_TEST_SEL);
  wire [7:0] wd_offset = ccr_masked(reg_wr_data, `CCR_MASK_OFFSET_TRIM);
  wire [7:0] wd_driver = ccr_masked(reg_wr_data, `CCR_MASK_OUT_DRIVER);
  wire [7:0] wd_phase  = ccr_masked(reg_wr_data, `CCR_MASK_OUT_PHASE);
  wire [7:0] wd_ref    = ccr_masked(reg_wr_data, `CCR_MASK_REF_LEVEL);

  // Register fields
  wire [2:0] pwr_field  = power_mode_reg[`CCR_PWR_MODE_LSB +: 3];
  wire       pin_stdby  = power_mode_reg[`CCR_PWR_PIN_FUNC_BIT];
  wire       drv_off    = out_driver_reg[`CCR_DRV_DISABLE_BIT];
  wire       drv_invert = out_driver_reg[`CCR_DRV_INVERT_BIT];
  wire [2:0] test_code  = test_sel_reg[`CCR_TEST_SEL_LSB +: 3];

  // Pin synchronisers, stage two and three agreeing
  wire power_down_pin_agree = (power_down_pin_sync_reg[1] == power_down_pin_sync_reg[2]);
  wire oe_agree   = (oe_sync_reg[1] == oe_sync_reg[2]);

  // Read data with unpopulated bits forced low
  always_comb
  begin
    case (reg_addr)
      `CCR_ADDR_POWER_MODE:
        rd_data_next = ccr_masked(power_mode_reg, `CCR_MASK_POWER_MODE);
      `CCR_ADDR_CLOCK_COND:
        rd_data_next = ccr_masked(clock_cond_reg, `CCR_MASK_CLOCK_COND);
      `CCR_ADDR_TEST_SEL:
        rd_data_next = ccr_masked(test_sel_reg, `CCR_MASK_TEST_SEL);
      `CCR_ADDR_OFFSET_TRIM:
        rd_data_next = ccr_masked(offset_trim_reg, `CCR_MASK_OFFSET_TRIM);
      `CCR_ADDR_OUT_DRIVER:
        rd_data_next = ccr_masked(out_driver_reg, `CCR_MASK_OUT_DRIVER);
      `CCR_ADDR_OUT_PHASE:
        rd_data_next = ccr_masked(out_phase_reg, `CCR_MASK_OUT_PHASE);
      `CCR_ADDR_REF_LEVEL:
        rd_data_next = ccr_masked(ref_level_reg, `CCR_MASK_REF_LEVEL);
      default:
        rd_data_next = 8'h00;
    endcase
  end

  // Effective power state, pin has priority
  always_comb
  begin
    if (power_down_pin_level_reg)
      power_next = pin_stdby ? CCR_PWR_STANDBY : CCR_PWR_DOWN;
    else
    begin
      case (pwr_field)
        `CCR_PM_FULL_DOWN: power_next = CCR_PWR_DOWN;
        `CCR_PM_STANDBY:   power_next = CCR_PWR_STANDBY;
        `CCR_PM_NORMAL_A:  power_next = CCR_PWR_NORMAL;
        `CCR_PM_NORMAL_B:  power_next = CCR_PWR_NORMAL;
        default:           power_next = CCR_PWR_NORMAL;
      endcase
    end
  end

  // Configuration registers with defaults on reset
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      power_mode_reg  <= `CCR_RST_POWER_MODE;
      clock_cond_reg  <= `CCR_RST_CLOCK_COND;
      test_sel_reg    <= `CCR_RST_TEST_SEL;
      offset_trim_reg <= `CCR_RST_OFFSET_TRIM;
      out_driver_reg  <= `CCR_RST_OUT_DRIVER;
      out_phase_reg   <= `CCR_RST_OUT_PHASE;
      ref_level_reg   <= `CCR_RST_REF_LEVEL;
    end
    else
    begin
      if (wr_power)
        power_mode_reg <= wd_power;
      if (wr_clock)
        clock_cond_reg <= wd_clock;
      if (wr_test)
        test_sel_reg <= wd_test;
      if (wr_offset)
        offset_trim_reg <= wd_offset;
      if (wr_driver)
        out_driver_reg <= wd_driver;
      if (wr_phase)
        out_phase_reg <= wd_phase;
      if (wr_ref)
        ref_level_reg <= wd_ref;
    end
  end

  // Read port answer
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      reg_rd_data  <= 8'h00;
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en)
        reg_rd_data <= rd_data_next;
    end
  end

  // Three-stage pin synchronisers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      power_down_pin_sync_reg  <= 3'h0;
      oe_sync_reg    <= 3'h0;
      power_down_pin_level_reg <= 1'b0;
      oe_level_reg   <= 1'b0;
    end
    else
    begin
      power_down_pin_sync_reg <= {power_down_pin_sync_reg[1:0], power_down_pin};
      oe_sync_reg   <= {oe_sync_reg[1:0], output_enable_low_pin};
      if (power_down_pin_agree)
        power_down_pin_level_reg <= power_down_pin_sync_reg[2];
      if (oe_agree)
        oe_level_reg <= oe_sync_reg[2];
    end
  end

  // Test word source
  ccr_pattern_gen #(
    .DATA_W          (DATA_W)
  ) u_pattern (
    .core_clk        (core_clk),
    .rst             (rst),
    .pattern_sel     (ccr_pattern_type'(test_code)),
    .long_prbs_hold  (test_sel_reg[`CCR_LONG_PRBS_RST]),
    .short_prbs_hold (test_sel_reg[`CCR_SHORT_PRBS_RST]),
    .conv_data       (conv_data),
    .pattern_data    (pattern_word)
  );

  // Registered outputs to the converter core
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      out_data            <= '0;
      out_data_oe         <= 1'b0;
      out_drive_strength  <= 2'h0;
      out_data_format     <= 2'h0;
      sample_clock_invert <= 1'b0;
      dcs_enable          <= 1'b0;
      offset_trim         <= 6'h00;
      ref_code            <= 2'h0;
      ref_level_mv        <= 12'h000;
      power_state         <= CCR_PWR_NORMAL;
    end
    else
    begin
      out_data            <= drv_invert ? ~pattern_word : pattern_word;
      out_data_oe         <= ~drv_off && oe_level_reg;
      out_drive_strength  <= out_driver_reg[`CCR_DRV_STRENGTH_LSB +: 2];
      out_data_format     <= out_driver_reg[`CCR_DRV_FORMAT_LSB +: 2];
      sample_clock_invert <= out_phase_reg[`CCR_PHASE_INV_BIT];
      dcs_enable          <= clock_cond_reg[`CCR_DCS_EN_BIT];
      offset_trim         <= offset_trim_reg[5:0];
      ref_code            <= ref_level_reg[`CCR_REF_CODE_LSB +: 2];
      ref_level_mv        <= ccr_ref_mv(
                               ref_level_reg[`CCR_REF_CODE_LSB +: 2]
                             );
      power_state         <= power_next;
    end
  end

endmodule : ccr_config_regs

/* File: tb/ccr_config_chk.sv */
`timescale 1ns/1ps
`include "ccr_defs.svh"

module ccr_config_chk
  import ccr_pkg::*;
(
  input wire logic          core_clk,
  input wire logic          rst,
  input wire logic          reg_wr_en,
  input wire logic          reg_rd_en,
  input wire logic [7:0]    reg_addr,
  input wire logic [7:0]    reg_wr_data,
  input wire logic [7:0]    reg_rd_data,
  input wire logic          reg_rd_valid,
  input wire logic          power_down_pin,
  input wire logic          output_enable_low_pin,
  input wire logic          out_data_oe,
  input wire logic          dcs_enable,
  input wire logic [1:0]    ref_code,
  input wire logic [11:0]   ref_level_mv,
  input wire ccr_power_type power_state
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // Pin levels held long enough to pass the synchronisers
  sequence s_oe_pin_low; !output_enable_low_pin [*8]; endsequence
  sequence s_pd_pin_high; power_down_pin [*8]; endsequence
  sequence s_ref_wr; reg_wr_en && reg_addr == `CCR_ADDR_REF_LEVEL; endsequence

  // Level and code always agree once out of reset
  property p_ref_map;
    !$past(rst) |-> ref_level_mv == (ref_code == 2'h0 ? `CCR_REF_MV_CODE0 :
      ref_code == 2'h1 ? `CCR_REF_MV_CODE1 :
      ref_code == 2'h2 ? `CCR_REF_MV_CODE2 : `CCR_REF_MV_CODE3);
  endproperty
  a_ref_map: assert property (p_ref_map)
    else $error("reference level does not match its code");

  // Written code shows two edges later
  property p_ref_wr;
    logic [1:0] d;
    (s_ref_wr, d = reg_wr_data[7:6]) |-> ##2 ref_code == d;
  endproperty
  a_ref_wr: assert property (p_ref_wr)
    else $error("reference code did not follow the write");

  property p_pd_pin;
    s_pd_pin_high |-> power_state != CCR_PWR_NORMAL;
  endproperty
  a_pd_pin: assert property (p_pd_pin)
    else $error("power-down pin did not override the mode field");

  property p_oe_pin;
    s_oe_pin_low |-> !out_data_oe;
  endproperty
  a_oe_pin: assert property (p_oe_pin)
    else $error("outputs drive while the enable pin is low");

  // Defaults visible right after release
  property p_dflt;
    $fell(rst) |-> power_state == CCR_PWR_NORMAL && !out_data_oe
      ##1 dcs_enable && ref_code == 2'h3;
  endproperty
  a_dflt: assert property (p_dflt)
    else $error("defaults missing after reset");

  property p_rd_open;
    reg_rd_en && reg_addr == `CCR_ADDR_CLOCK_COND |=>
      reg_rd_valid && reg_rd_data[7:1] == 7'h00;
  endproperty
  a_rd_open: assert property (p_rd_open)
    else $error("open bits read back nonzero");

  property p_rd_unmapped;
    reg_rd_en && reg_addr == 8'h13 |=> reg_rd_valid && reg_rd_data == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read returned nonzero");
endmodule : ccr_config_chk

bind ccr_config_regs ccr_config_chk u_ccr_config_chk (.core_clk, .rst,
  .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data,
  .reg_rd_valid, .power_down_pin, .output_enable_low_pin, .out_data_oe,
  .dcs_enable, .ref_code, .ref_level_mv, .power_state);

/* File: tb/ccr_host_model.sv */
`timescale 1ns/1ps
`include "ccr_defs.svh"

module ccr_host_model (
  input  wire logic       core_clk,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wr_data,
  input  wire logic [7:0] reg_rd_data,
  input  wire logic       reg_rd_valid
);
  // Populated bits per register
  function automatic logic [7:0] fill_mask(input logic [7:0] a);
    case (a)
      `CCR_ADDR_POWER_MODE:  fill_mask = `CCR_MASK_POWER_MODE;
      `CCR_ADDR_CLOCK_COND:  fill_mask = `CCR_MASK_CLOCK_COND;
      `CCR_ADDR_TEST_SEL:    fill_mask = `CCR_MASK_TEST_SEL;
      `CCR_ADDR_OFFSET_TRIM: fill_mask = `CCR_MASK_OFFSET_TRIM;
      `CCR_ADDR_OUT_DRIVER:  fill_mask = `CCR_MASK_OUT_DRIVER;
      `CCR_ADDR_OUT_PHASE:   fill_mask = `CCR_MASK_OUT_PHASE;
      `CCR_ADDR_REF_LEVEL:   fill_mask = `CCR_MASK_REF_LEVEL;
      default:               fill_mask = 8'h00;
    endcase
  endfunction : fill_mask

  initial
  begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
  end

  // One write; raw keeps open bits as given
  task automatic write(input logic [7:0] a, input logic [7:0] d,
                       input bit raw);
    @(negedge core_clk);
    reg_addr = a;
    reg_wr_data = raw ? d : d & fill_mask(a);
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    reg_addr = ~reg_addr;
    reg_wr_data = ~reg_wr_data;
  endtask : write

  // One read, bounded wait for the valid pulse
  task automatic read(input logic [7:0] a, output logic [7:0] d,
                      output bit ok);
    int n;
    @(negedge core_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    reg_addr = ~reg_addr;
    ok = 1'b0;
    d = 8'h00;
    for (n = 0; n < 4 && !ok; n++)
    begin
      if (reg_rd_valid === 1'b1)
      begin
        ok = 1'b1;
        d = reg_rd_data;
      end
      else
        @(negedge core_clk);
    end
  endtask : read
endmodule : ccr_host_model

/* File: tb/converter_config_registers_test.sv */
`timescale 1ns/1ps
`include "ccr_defs.svh"
`define CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); \
    end \
  end

module converter_config_registers_test
  import ccr_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic pd_pin = 1'b0;
  logic oe_pin = 1'b1;
  logic [11:0] conv = 12'h3C5;
  logic wr_en, rd_en, rd_valid, oe;
  logic [7:0] addr, wdata, rdata;
  logic [11:0] odata, mv;
  logic [1:0] rcode;
  logic dcs;
  logic clk_inv;
  logic [1:0] drv_str, drv_fmt;
  logic [5:0] trim;
  ccr_power_type pst;
  int n_mismatch = 0;
  int samples_checked = 0;
  localparam logic [7:0] ADDRS [7] = '{8'h08, 8'h09, 8'h0D, 8'h10, 8'h14,
                                      8'h16, 8'h18};
  localparam logic [7:0] DFLT [7] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00,
                                     8'h00, 8'hC0};
  localparam logic [7:0] MASKS [7] = '{8'h27, 8'h01, 8'h37, 8'h3F, 8'hD7,
                                      8'h80, 8'hC0};
  localparam logic [11:0] REFMV [4] = '{12'h4E2, 12'h5DC, 12'h6D6, 12'h7D0};
  localparam ccr_power_type PST [4] = '{CCR_PWR_NORMAL, CCR_PWR_DOWN,
                                       CCR_PWR_STANDBY, CCR_PWR_NORMAL};

  always #5 core_clk = ~core_clk;

  ccr_host_model u_ccr_host_model (.core_clk(core_clk), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wr_data(wdata),
    .reg_rd_data(rdata), .reg_rd_valid(rd_valid));

  ccr_config_regs u_ccr_config_regs (.core_clk(core_clk), .rst(rst),
    .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_wr_data(wdata), .reg_rd_data(rdata), .reg_rd_valid(rd_valid),
    .power_down_pin(pd_pin), .output_enable_low_pin(oe_pin),
    .conv_data(conv), .out_data(odata), .out_data_oe(oe),
    .out_drive_strength(drv_str), .out_data_format(drv_fmt),
    .sample_clock_invert(clk_inv), .dcs_enable(dcs),
    .offset_trim(trim), .ref_code(rcode),
    .ref_level_mv(mv), .power_state(pst));

  task automatic final_report();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_ccr_host_model.write(a, d, 1'b0);
  endtask : wr

  // Read with timeout going to the report
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bit ok;
    u_ccr_host_model.read(a, d, ok);
    if (!ok)
    begin
      n_mismatch++;
      final_report();
    end
  endtask : rd

  task automatic t_defaults();
    logic [7:0] d;
    for (int i = 0; i < 7; i++)
    begin
      rd(ADDRS[i], d);
      `CHK(d, DFLT[i])
    end
    `CHK(dcs, 1'b1)
    `CHK(mv, 12'h7D0)
    `CHK(pst, CCR_PWR_NORMAL)
    `CHK(drv_str, 2'h0)
    `CHK(drv_fmt, 2'h0)
    `CHK(clk_inv, 1'b0)
    `CHK(trim, 6'h00)
    $display("defaults test done");
  endtask : t_defaults

  task automatic t_open_bits();
    logic [7:0] d;
    for (int i = 0; i < 7; i++)
    begin
      u_ccr_host_model.write(ADDRS[i], 8'hFF, 1'b1);
      rd(ADDRS[i], d);
      `CHK(d, MASKS[i])
      wr(ADDRS[i], DFLT[i]);
    end
    u_ccr_host_model.write(8'h13, 8'hFF, 1'b1);
    rd(8'h13, d);
    `CHK(d, 8'h00)
    $display("open bits test done");
  endtask : t_open_bits

  task automatic t_ref();
    for (int c = 0; c < 4; c++)
    begin
      wr(`CCR_ADDR_REF_LEVEL, {c[1:0], 6'h00});
      tick(3);
      `CHK(rcode, c[1:0])
      `CHK(mv, REFMV[c])
    end
    $display("reference test done");
  endtask : t_ref

  task automatic t_power();
    for (int c = 0; c < 4; c++)
    begin
      wr(`CCR_ADDR_POWER_MODE, {5'h00, c[2:0]});
      tick(3);
      `CHK(pst, PST[c])
    end
    pd_pin = 1'b1;
    wr(`CCR_ADDR_POWER_MODE, 8'h20);
    tick(8);
    `CHK(pst, CCR_PWR_STANDBY)
    wr(`CCR_ADDR_POWER_MODE, 8'h00);
    tick(3);
    `CHK(pst, CCR_PWR_DOWN)
    pd_pin = 1'b0;
    tick(8);
    `CHK(pst, CCR_PWR_NORMAL)
    $display("power test done");
  endtask : t_power

  task automatic t_oe();
    `CHK(oe, 1'b1)
    wr(`CCR_ADDR_OUT_DRIVER, 8'h10);
    tick(3);
    `CHK(oe, 1'b0)
    wr(`CCR_ADDR_OUT_DRIVER, 8'h00);
    tick(3);
    `CHK(oe, 1'b1)
    oe_pin = 1'b0;
    tick(8);
    `CHK(oe, 1'b0)
    oe_pin = 1'b1;
    tick(8);
    `CHK(oe, 1'b1)
    $display("output enable test done");
  endtask : t_oe

  // Field outputs after raw writes, open bits dropped
  task automatic t_fields();
    u_ccr_host_model.write(`CCR_ADDR_OUT_DRIVER, 8'hFF, 1'b1);
    u_ccr_host_model.write(`CCR_ADDR_OUT_PHASE, 8'hFF, 1'b1);
    u_ccr_host_model.write(`CCR_ADDR_OFFSET_TRIM, 8'hFF, 1'b1);
    u_ccr_host_model.write(`CCR_ADDR_CLOCK_COND, 8'hFE, 1'b1);
    tick(3);
    `CHK(drv_str, 2'h3)
    `CHK(drv_fmt, 2'h3)
    `CHK(clk_inv, 1'b1)
    `CHK(trim, 6'h3F)
    `CHK(dcs, 1'b0)
    `CHK(oe, 1'b0)
    u_ccr_host_model.write(`CCR_ADDR_OUT_DRIVER, 8'hAA, 1'b1);
    u_ccr_host_model.write(`CCR_ADDR_OUT_PHASE, 8'h7F, 1'b1);
    u_ccr_host_model.write(`CCR_ADDR_OFFSET_TRIM, 8'hD5, 1'b1);
    u_ccr_host_model.write(`CCR_ADDR_CLOCK_COND, 8'hFF, 1'b1);
    tick(3);
    `CHK(drv_str, 2'h2)
    `CHK(drv_fmt, 2'h2)
    `CHK(clk_inv, 1'b0)
    `CHK(trim, 6'h15)
    `CHK(dcs, 1'b1)
    `CHK(oe, 1'b1)
    wr(`CCR_ADDR_OUT_DRIVER, 8'h00);
    wr(`CCR_ADDR_OFFSET_TRIM, 8'h00);
    $display("field output test done");
  endtask : t_fields

  // Every selector code, PRBS held at seed
  task automatic t_patterns();
    logic [11:0] a, b;
    for (int s = 0; s < 8; s++)
    begin
      wr(`CCR_ADDR_TEST_SEL, 8'h30 | 8'(s));
      tick(4);
      a = odata;
      tick(1);
      b = odata;
      case (s)
        0: `CHK(a, conv)
        1: `CHK(a, `CCR_PAT_MIDSCALE)
        2: `CHK(a, `CCR_PAT_POS_FULL)
        3: `CHK(a, `CCR_PAT_NEG_FULL)
        4: `CHK((a === 12'hAAA) && (b === 12'h555) ||
                (a === 12'h555) && (b === 12'hAAA), 1'b1)
        5: `CHK(a, 12'hFFF)
        6: `CHK(a, 12'h1FF)
        default: `CHK((a ^ b) === 12'hFFF && (a === 12'h000 ||
                      a === 12'hFFF), 1'b1)
      endcase
    end
    wr(`CCR_ADDR_TEST_SEL, 8'h05);
    tick(30);
    `CHK(odata !== 12'hFFF, 1'b1)
    wr(`CCR_ADDR_TEST_SEL, 8'h01);
    wr(`CCR_ADDR_OUT_DRIVER, 8'h04);
    tick(4);
    `CHK(odata, `CCR_PAT_MIDSCALE ^ 12'hFFF)
    $display("pattern test done");
  endtask : t_patterns

  initial
  begin
    tick(5);
    rst = 1'b0;
    t_defaults();
    t_open_bits();
    t_ref();
    t_power();
    t_oe();
    t_fields();
    t_patterns();
    final_report();
  end
endmodule : converter_config_registers_test
